/* File: rtl/repeater_lane_config_regs.sv */
// Lane configuration register bank: channel 0 emphasis and idle threshold,
// channel 1 idle/rate select, receive boost and output swing.
// Assumes an APB master on pclk and strap pins that are static after reset.
//
// Contract
// R1: Bit 7 style, bits 6:0 emphasis level
// R2: Emphasis strap codes load fixed values
// R3: Software never programs emphasis value C0h
// R4: Threshold bits 3:2 deassert, 1:0 assert
// R5: Threshold codes select fixed mV levels
// R6: Bit 5 picks manual or auto idle
// R7: Auto 0 honours select; 1 auto
// R8: Select 0 output on; 1 muted
// R9: Bit 1 picks manual or auto rate
// R10: Rate select 0 low range, 1 high
// R11: Boost enable, stage, level fields decoded
// R12: Boost register defaults to 20h bypass
// R13: Boost strap codes load fixed values
// R14: Swing codes select fixed mV levels
// R15: Reserved bits read zero, fields read back
`timescale 1ns/1ps
module repeater_lane_config_regs
  import lane_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] emphasis_strap_pin_a,
  input wire logic [1:0] emphasis_strap_pin_b,
  input wire logic [1:0] boost_strap_pin_a,
  input wire logic [1:0] boost_strap_pin_b,
  input wire logic strap_mode,
  output logic strap_loaded,
  output logic ch0_emphasis_style,
  output logic [6:0] ch0_emphasis_level,
  output logic ch0_emphasis_reserved,
  output logic [7:0] ch0_deassert_mv,
  output logic [7:0] ch0_assert_mv,
  output logic ch1_out_mute,
  output logic ch1_signal_detect_en,
  output logic ch1_rate_auto_en,
  output logic ch1_rate_range_high,
  output logic ch1_boost_enable,
  output logic [1:0] ch1_boost_stage,
  output logic [2:0] ch1_boost_level,
  output logic [10:0] ch1_swing_mv
);
  typedef enum logic [1:0] {st_settle, st_load, st_run} strap_state_t;

  reg_access_if ra ();

  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  strap_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic loaded_q, loaded_d;
  logic [7:0] emph_q, emph_d;
  logic [7:0] thresh_q, thresh_d;
  logic [7:0] speed_q, speed_d;
  logic [7:0] boost_q, boost_d;
  logic [7:0] swing_q, swing_d;
  logic [7:0] strap_emph;
  logic [7:0] strap_boost;

  function automatic logic [10:0] swing_to_mv(input logic [5:0] code);
    case (code)
      SWING_C600: swing_to_mv = SWING_MV600;
      SWING_C800: swing_to_mv = SWING_MV800;
      SWING_C1000: swing_to_mv = SWING_MV1000;
      SWING_C1200: swing_to_mv = SWING_MV1200;
      SWING_C1400: swing_to_mv = SWING_MV1400;
      default: swing_to_mv = 11'h000;
    endcase
  endfunction : swing_to_mv

  function automatic logic is_mapped(input logic [4:0] idx);
    if (idx == IDX_EMPH) begin
      is_mapped = 1'b1;
    end else if (idx == IDX_THRESH) begin
      is_mapped = 1'b1;
    end else if (idx == IDX_SPEED) begin
      is_mapped = 1'b1;
    end else if (idx == IDX_BOOST) begin
      is_mapped = 1'b1;
    end else if (idx == IDX_SWING) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction : is_mapped

  lane_cfg_apb #(.ADDR_W(ADDR_W)) u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ra(ra.bus)
  );

  strap_code_map u_strap (
    .emph_pin_a(strap_level_t'(sync2_q[1:0])),
    .emph_pin_b(strap_level_t'(sync2_q[3:2])),
    .boost_pin_a(strap_level_t'(sync2_q[5:4])),
    .boost_pin_b(strap_level_t'(sync2_q[7:6])),
    .emph_value(strap_emph),
    .boost_value(strap_boost)
  );

  // Strap pins are asynchronous to pclk; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {strap_mode, boost_strap_pin_b, boost_strap_pin_a,
                  emphasis_strap_pin_b, emphasis_strap_pin_a};
      sync2_q <= sync1_q;
    end
  end

  // R15 reserved bits read zero
  assign ra.hit = is_mapped(ra.idx);
  always_comb begin
    if (ra.idx == IDX_EMPH) begin
      ra.rdata = emph_q;
    end else if (ra.idx == IDX_THRESH) begin
      ra.rdata = thresh_q;
    end else if (ra.idx == IDX_SPEED) begin
      ra.rdata = speed_q;
    end else if (ra.idx == IDX_BOOST) begin
      ra.rdata = boost_q;
    end else if (ra.idx == IDX_SWING) begin
      ra.rdata = swing_q;
    end else begin
      ra.rdata = 8'h00;
    end
  end

  // Straps are sampled once, after the synchroniser has filled
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    loaded_d = loaded_q;
    emph_d = emph_q;
    thresh_d = thresh_q;
    speed_d = speed_q;
    boost_d = boost_q;
    swing_d = swing_q;
    case (state_q)
      st_settle: begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == STRAP_SETTLE_CYCLES - 2'h1) begin
          state_d = st_load;
        end
      end
      st_load: begin
        state_d = st_run;
        // R2 emphasis strap load
        // R13 boost strap load
        if (sync2_q[8]) begin
          emph_d = strap_emph;
          boost_d = strap_boost;
          loaded_d = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // R15 fields store written bits only
    if (ra.wr) begin
      if (ra.idx == IDX_EMPH) begin
        emph_d = ra.wdata & MASK_EMPH;
      end else if (ra.idx == IDX_THRESH) begin
        thresh_d = ra.wdata & MASK_THRESH;
      end else if (ra.idx == IDX_SPEED) begin
        speed_d = ra.wdata & MASK_SPEED;
      end else if (ra.idx == IDX_BOOST) begin
        boost_d = ra.wdata & MASK_BOOST;
      end else if (ra.idx == IDX_SWING) begin
        swing_d = ra.wdata & MASK_SWING;
      end
    end
  end

  // R12 boost bypass default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_settle;
      cnt_q <= 2'h0;
      loaded_q <= 1'b0;
      emph_q <= RST_EMPH;
      thresh_q <= RST_THRESH;
      speed_q <= RST_SPEED;
      boost_q <= RST_BOOST;
      swing_q <= RST_SWING;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      loaded_q <= loaded_d;
      emph_q <= emph_d;
      thresh_q <= thresh_d;
      speed_q <= speed_d;
      boost_q <= boost_d;
      swing_q <= swing_d;
    end
  end

  assign strap_loaded = loaded_q;
  // R1 style and level split
  assign ch0_emphasis_style = emph_q[EMPH_STYLE_BIT];
  assign ch0_emphasis_level = emph_q[6:0];
  // R3 flag the value software must avoid
  assign ch0_emphasis_reserved = (emph_q == EMPH_RESERVED);
  // R4 threshold halves decoded
  // R5 threshold mV lookup
  assign ch0_deassert_mv = DEASSERT_MV[thresh_q[THR_DEASSERT_LSB +: 2]];
  assign ch0_assert_mv = ASSERT_MV[thresh_q[THR_ASSERT_LSB +: 2]];
  // R6 idle source select
  // R7 manual or automatic idle
  // R8 manual mute or on
  assign ch1_out_mute = !speed_q[SPEED_IDLE_AUTO_BIT] && speed_q[SPEED_IDLE_SEL_BIT];
  assign ch1_signal_detect_en = speed_q[SPEED_IDLE_AUTO_BIT];
  // R9 rate source select
  // R10 manual rate range
  assign ch1_rate_auto_en = speed_q[SPEED_RATE_AUTO_BIT];
  assign ch1_rate_range_high = speed_q[SPEED_RATE_SEL_BIT];
  // R11 boost field decode
  assign ch1_boost_enable = boost_q[BOOST_EN_BIT];
  assign ch1_boost_stage = boost_q[BOOST_STAGE_LSB +: 2];
  assign ch1_boost_level = boost_q[BOOST_LEVEL_LSB +: 3];
  // R14 swing mV lookup
  assign ch1_swing_mv = swing_to_mv(swing_q[5:0]);

  sequence s_wr_emph;
    ra.wr && ra.idx == IDX_EMPH;
  endsequence

  sequence s_wr_thresh;
    ra.wr && ra.idx == IDX_THRESH;
  endsequence

  sequence s_wr_boost;
    ra.wr && ra.idx == IDX_BOOST;
  endsequence

  sequence s_strap_take;
    state_q == st_load && sync2_q[8];
  endsequence

  a_emph_style_write: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    s_wr_emph |=> ch0_emphasis_style == $past(ra.wdata[7]) &&
      ch0_emphasis_level == $past(ra.wdata[6:0]))
    else $error("emphasis style or level not taken from write");

  a_strap_emph_load: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    s_strap_take ##1 !ra.wr [*1] |-> emph_q == $past(strap_emph, 1) || $past(ra.wr))
    else $error("emphasis strap value not loaded");

  a_thresh_split: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    s_wr_thresh |=> ch0_deassert_mv == DEASSERT_MV[$past(ra.wdata[3:2])] &&
      ch0_assert_mv == ASSERT_MV[$past(ra.wdata[1:0])])
    else $error("threshold halves swapped or stale");

  a_thresh_default: assert property ( // R5
    @(posedge pclk) $rose(presetn) |-> ch0_deassert_mv == 8'h6e && ch0_assert_mv == 8'h46)
    else $error("threshold default is not 110/70 mV");

  a_idle_manual_mute: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    !speed_q[5] && speed_q[4] |-> ch1_out_mute && !ch1_signal_detect_en)
    else $error("manual idle select not honoured");

  a_idle_auto_owns: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    speed_q[5] || !speed_q[4] |-> !ch1_out_mute)
    else $error("output muted when it should be on");

  a_rate_source: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    ra.wr && ra.idx == IDX_SPEED |=> ch1_rate_auto_en == $past(ra.wdata[1]) &&
      ch1_rate_range_high == $past(ra.wdata[0]))
    else $error("rate source or range not taken");

  a_boost_fields: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    s_wr_boost |=> {ch1_boost_enable, ch1_boost_stage, ch1_boost_level} ==
      $past(ra.wdata[5:0]) && boost_q[7:6] == 2'h0)
    else $error("boost fields decoded wrongly");

  a_boost_default: assert property ( // R12
    @(posedge pclk) $rose(presetn) |-> boost_q == 8'h20 && ch1_boost_enable)
    else $error("boost register not in bypass after reset");

  a_swing_top_code: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    swing_q == 8'h3f |-> ch1_swing_mv == 11'h578)
    else $error("swing code 3f not 1400 mV");

  a_reserved_zero: assert property ( // R15
    @(posedge pclk) disable iff (!presetn)
    ra.idx == IDX_SPEED |-> ra.rdata[7:6] == 2'h0 && ra.rdata[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
endmodule : repeater_lane_config_regs

/* File: rtl/lane_cfg_pkg.sv */
// Constants for the repeater lane configuration register bank.
// Assumes a 32-bit APB slave; each register sits at four times its index.
package lane_cfg_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [4:0] IDX_EMPH = 5'h11;
  localparam logic [4:0] IDX_THRESH = 5'h12;
  localparam logic [4:0] IDX_SPEED = 5'h15;
  localparam logic [4:0] IDX_BOOST = 5'h16;
  localparam logic [4:0] IDX_SWING = 5'h17;

  // Values after reset
  localparam logic [7:0] RST_EMPH = 8'h03;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'h20;
  localparam logic [7:0] RST_SWING = 8'h03;

  // Writable bits per register; the rest read as zero
  localparam logic [7:0] MASK_EMPH = 8'hff;
  localparam logic [7:0] MASK_THRESH = 8'h0f;
  localparam logic [7:0] MASK_SPEED = 8'h33;
  localparam logic [7:0] MASK_BOOST = 8'h3f;
  localparam logic [7:0] MASK_SWING = 8'h3f;

  // Field positions
  localparam int EMPH_STYLE_BIT = 7;
  localparam int THR_DEASSERT_LSB = 2;
  localparam int THR_ASSERT_LSB = 0;
  localparam int SPEED_IDLE_AUTO_BIT = 5;
  localparam int SPEED_IDLE_SEL_BIT = 4;
  localparam int SPEED_RATE_AUTO_BIT = 1;
  localparam int SPEED_RATE_SEL_BIT = 0;
  localparam int BOOST_EN_BIT = 5;
  localparam int BOOST_STAGE_LSB = 3;
  localparam int BOOST_LEVEL_LSB = 0;

  localparam logic [7:0] EMPH_RESERVED = 8'hc0;

  // Threshold levels in mV, indexed by the two-bit code
  localparam logic [3:0][7:0] DEASSERT_MV = {8'hbe, 8'haa, 8'h96, 8'h6e};
  localparam logic [3:0][7:0] ASSERT_MV = {8'h96, 8'h82, 8'h6e, 8'h46};

  // Swing codes and their levels in mV
  localparam logic [5:0] SWING_C600 = 6'h03;
  localparam logic [5:0] SWING_C800 = 6'h07;
  localparam logic [5:0] SWING_C1000 = 6'h0f;
  localparam logic [5:0] SWING_C1200 = 6'h1f;
  localparam logic [5:0] SWING_C1400 = 6'h3f;
  localparam logic [10:0] SWING_MV600 = 11'h258;
  localparam logic [10:0] SWING_MV800 = 11'h320;
  localparam logic [10:0] SWING_MV1000 = 11'h3e8;
  localparam logic [10:0] SWING_MV1200 = 11'h4b0;
  localparam logic [10:0] SWING_MV1400 = 11'h578;

  // Three-level strap pin coding
  typedef enum logic [1:0] {
    strap_low = 2'h0,
    strap_high = 2'h1,
    strap_float = 2'h2
  } strap_level_t;

  // Strap code to register value
  localparam logic [7:0] STRAP_EMPH_00 = 8'h01;
  localparam logic [7:0] STRAP_EMPH_01 = 8'h38;
  localparam logic [7:0] STRAP_EMPH_0F = 8'h88;
  localparam logic [7:0] STRAP_EMPH_F0 = 8'h90;
  localparam logic [7:0] STRAP_EMPH_1F = 8'ha0;
  localparam logic [7:0] STRAP_EMPH_F1 = 8'ha0;
  localparam logic [7:0] STRAP_EMPH_FF = 8'hc0;
  localparam logic [7:0] STRAP_BOOST_FF = 8'h20;
  localparam logic [7:0] STRAP_BOOST_11 = 8'h2a;
  localparam logic [7:0] STRAP_BOOST_00 = 8'h30;
  localparam logic [7:0] STRAP_BOOST_0F = 8'h31;
  localparam logic [7:0] STRAP_BOOST_01 = 8'h38;
  localparam logic [7:0] STRAP_BOOST_1F = 8'h34;
  localparam logic [7:0] STRAP_BOOST_10 = 8'h35;
  localparam logic [7:0] STRAP_BOOST_F0 = 8'h3a;
  localparam logic [7:0] STRAP_BOOST_F1 = 8'h3c;

  // Edges after reset release before synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

endpackage : lane_cfg_pkg

/* File: rtl/reg_access_if.sv */
// Register access path between the APB front end and the register bank.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface reg_access_if;
  logic wr;
  logic [4:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport bus (output wr, output idx, output wdata, input rdata, input hit);
  modport bank (input wr, input idx, input wdata, output rdata, output hit);
endinterface : reg_access_if

/* File: rtl/lane_cfg_apb.sv */
// APB slave front end: zero wait states, error on unmapped or misaligned address.
// Assumes the bank answers rdata and hit combinationally from idx.
`timescale 1ns/1ps
module lane_cfg_apb
  import lane_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  reg_access_if.bus ra
);
  logic ok;
  logic top_ok;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  if (ADDR_W < 7) begin : g_bad_width
    $error("ADDR_W must reach the top register");
  end

  // A seven-bit bus has no bits above the map to check
  if (ADDR_W > 7) begin : g_top_bits
    assign top_ok = (paddr[ADDR_W-1:7] == '0);
  end else begin : g_no_top_bits
    assign top_ok = 1'b1;
  end

  assign ok = (paddr[1:0] == 2'h0) && top_ok && ra.hit;
  assign ra.idx = paddr[6:2];
  assign ra.wdata = pwdata[7:0];
  assign ra.wr = psel && penable && pwrite && ok;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !ok;
  assign prdata = prdata_q;

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable) begin
      prdata_d = (ok && !pwrite) ? {24'h000000, ra.rdata} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end
endmodule : lane_cfg_apb

/* File: rtl/strap_code_map.sv */
// Maps three-level strap pin pairs onto register values.
// Assumes the pin levels are already synchronised.
`timescale 1ns/1ps
module strap_code_map
  import lane_cfg_pkg::*;
(
  input wire strap_level_t emph_pin_a,
  input wire strap_level_t emph_pin_b,
  input wire strap_level_t boost_pin_a,
  input wire strap_level_t boost_pin_b,
  output logic [7:0] emph_value,
  output logic [7:0] boost_value
);
  // Emphasis code is written second pin then first pin, boost code first pin then second pin
  always_comb begin
    case ({emph_pin_b, emph_pin_a})
      {strap_low, strap_low}: emph_value = STRAP_EMPH_00;
      {strap_low, strap_high}: emph_value = STRAP_EMPH_01;
      {strap_low, strap_float}: emph_value = STRAP_EMPH_0F;
      {strap_float, strap_low}: emph_value = STRAP_EMPH_F0;
      {strap_high, strap_float}: emph_value = STRAP_EMPH_1F;
      {strap_float, strap_high}: emph_value = STRAP_EMPH_F1;
      {strap_float, strap_float}: emph_value = STRAP_EMPH_FF;
      // Codes with no table entry fall back to 0 dB
      default: emph_value = STRAP_EMPH_00;
    endcase
  end

  always_comb begin
    case ({boost_pin_a, boost_pin_b})
      {strap_high, strap_high}: boost_value = STRAP_BOOST_11;
      {strap_low, strap_low}: boost_value = STRAP_BOOST_00;
      {strap_low, strap_float}: boost_value = STRAP_BOOST_0F;
      {strap_low, strap_high}: boost_value = STRAP_BOOST_01;
      {strap_high, strap_float}: boost_value = STRAP_BOOST_1F;
      {strap_high, strap_low}: boost_value = STRAP_BOOST_10;
      {strap_float, strap_low}: boost_value = STRAP_BOOST_F0;
      {strap_float, strap_high}: boost_value = STRAP_BOOST_F1;
      default: boost_value = STRAP_BOOST_FF;
    endcase
  end
endmodule : strap_code_map

/* File: verif/testbench.sv */
// Self-checking bench for the lane configuration register bank.
// Assumes a zero-wait APB slave and strap values loaded three edges after reset.
`timescale 1ns/1ps
module testbench;
  import lane_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ep_a, ep_b, bp_a, bp_b;
  logic strap_mode, strap_loaded, err;
  logic ch0_emphasis_style, ch0_emphasis_reserved;
  logic [6:0] ch0_emphasis_level;
  logic [7:0] ch0_deassert_mv, ch0_assert_mv;
  logic ch1_out_mute, ch1_signal_detect_en, ch1_rate_auto_en, ch1_rate_range_high;
  logic ch1_boost_enable;
  logic [1:0] ch1_boost_stage;
  logic [2:0] ch1_boost_level;
  logic [10:0] ch1_swing_mv;
  int n_mismatch = 0;
  int checked = 0;

  repeater_lane_config_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .emphasis_strap_pin_a(ep_a), .emphasis_strap_pin_b(ep_b),
    .boost_strap_pin_a(bp_a), .boost_strap_pin_b(bp_b),
    .strap_mode(strap_mode), .strap_loaded(strap_loaded),
    .ch0_emphasis_style(ch0_emphasis_style), .ch0_emphasis_level(ch0_emphasis_level),
    .ch0_emphasis_reserved(ch0_emphasis_reserved),
    .ch0_deassert_mv(ch0_deassert_mv), .ch0_assert_mv(ch0_assert_mv),
    .ch1_out_mute(ch1_out_mute), .ch1_signal_detect_en(ch1_signal_detect_en),
    .ch1_rate_auto_en(ch1_rate_auto_en), .ch1_rate_range_high(ch1_rate_range_high),
    .ch1_boost_enable(ch1_boost_enable), .ch1_boost_stage(ch1_boost_stage),
    .ch1_boost_level(ch1_boost_level), .ch1_swing_mv(ch1_swing_mv)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [7:0] ra(input logic [4:0] i);
    return {1'h0, i, 2'h0};
  endfunction : ra

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; waits for pready, takes data and error at that edge
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
    chk(err, 1'b0);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    chk(err, 1'b0);
    chk(rd, e);
  endtask : rchk

  task automatic rst(input logic sm);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_mode <= sm;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : rst

  task automatic t_reset;
    rchk(ra(IDX_EMPH), 32'h03);
    rchk(ra(IDX_THRESH), 32'h00);
    rchk(ra(IDX_SPEED), 32'h00);
    rchk(ra(IDX_BOOST), 32'h20);
    rchk(ra(IDX_SWING), 32'h03);
    @(negedge pclk);
    chk(ch0_deassert_mv, 8'h6e);
    chk(ch0_assert_mv, 8'h46);
    chk(ch1_swing_mv, 11'h258);
    chk(ch1_boost_enable, 1'h1);
    chk(strap_loaded, 1'h0);
  endtask : t_reset

  // software never writes the reserved emphasis value
  task automatic t_emph;
    wr(ra(IDX_EMPH), 32'hffffff88);
    @(negedge pclk);
    chk(ch0_emphasis_style, 1'h1);
    chk(ch0_emphasis_level, 7'h08);
    chk(ch0_emphasis_reserved, 1'h0);
    rchk(ra(IDX_EMPH), 32'h88);
    wr(ra(IDX_EMPH), 32'h38);
    @(negedge pclk);
    chk({ch0_emphasis_style, ch0_emphasis_level}, 8'h38);
  endtask : t_emph

  task automatic t_thresh;
    logic [7:0] dm [4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
    logic [7:0] am [4] = '{8'h46, 8'h6e, 8'h82, 8'h96};
    // Opposite codes in the two halves expose swapped fields
    for (int c = 0; c < 4; c++) begin
      wr(ra(IDX_THRESH), {28'h0, 2'(c), 2'(3 - c)});
      @(negedge pclk);
      chk(ch0_deassert_mv, dm[c]);
      chk(ch0_assert_mv, am[3 - c]);
    end
    wr(ra(IDX_THRESH), 32'hff);
    rchk(ra(IDX_THRESH), 32'h0f);
  endtask : t_thresh

  task automatic t_speed;
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 8'hcc | {2'h0, i[3], i[2], 2'h0, i[1], i[0]};
      wr(ra(IDX_SPEED), {24'h0, v});
      @(negedge pclk);
      chk(ch1_out_mute, !i[3] && i[2]);
      chk(ch1_signal_detect_en, i[3]);
      chk(ch1_rate_auto_en, i[1]);
      chk(ch1_rate_range_high, i[0]);
      rchk(ra(IDX_SPEED), {24'h0, v & 8'h33});
    end
  endtask : t_speed

  task automatic t_boost;
    logic [7:0] bv [3] = '{8'hfc, 8'h2a, 8'h57};
    foreach (bv[k]) begin
      wr(ra(IDX_BOOST), {24'hffffff, bv[k]});
      @(negedge pclk);
      chk({ch1_boost_enable, ch1_boost_stage, ch1_boost_level}, bv[k][5:0]);
      rchk(ra(IDX_BOOST), {24'h0, bv[k] & 8'h3f});
    end
  endtask : t_boost

  task automatic t_swing;
    logic [7:0] sc [6] = '{8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h05};
    logic [10:0] sv [6] = '{11'h258, 11'h320, 11'h3e8, 11'h4b0, 11'h578, 11'h000};
    foreach (sc[k]) begin
      wr(ra(IDX_SWING), {24'h0, sc[k] | 8'hc0});
      @(negedge pclk);
      chk(ch1_swing_mv, sv[k]);
      rchk(ra(IDX_SWING), {24'h0, sc[k]});
    end
  endtask : t_swing

  task automatic t_refuse;
    acc(8'h4c, 1'b1, 32'h55);
    chk(err, 1'h1);
    acc(8'h45, 1'b1, 32'h55);
    chk(err, 1'h1);
    acc(8'hc4, 1'b0, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
    rchk(ra(IDX_EMPH), 32'h38);
  endtask : t_refuse

  // Pin levels packed as {second pin, first pin, value} for emphasis, {first pin, second pin, value} for boost; 0 low, 1 high, 2 float
  task automatic t_strap;
    logic [11:0] et [7] = '{12'h001, 12'h138, 12'h288, 12'h890, 12'h6a0, 12'h9a0,
                            12'hac0};
    logic [11:0] bt [9] = '{12'ha20, 12'h52a, 12'h030, 12'h231, 12'h138, 12'h634,
                            12'h435, 12'h83a, 12'h93c};
    logic [11:0] e;
    for (int k = 0; k < 9; k++) begin
      e = et[k % 7];
      {ep_b, ep_a} <= e[11:8];
      {bp_a, bp_b} <= bt[k][11:8];
      rst(1'b1);
      @(negedge pclk);
      chk(strap_loaded, 1'h1);
      chk(ch0_emphasis_reserved, e[7:0] == 8'hc0);
      rchk(ra(IDX_EMPH), {24'h0, e[7:0]});
      rchk(ra(IDX_BOOST), {24'h0, bt[k][7:0]});
    end
    rst(1'b0);
  endtask : t_strap

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap_mode = 1'b0;
    {ep_a, ep_b, bp_a, bp_b} = 8'h00;
    rst(1'b0);
    t_reset;
    t_emph;
    t_thresh;
    t_speed;
    t_boost;
    t_swing;
    t_refuse;
    t_strap;
    results;
  end

  // Whole run is about 450 cycles; five thousand means a hang
  initial begin
    #125000;
    n_mismatch++;
    results;
  end
endmodule : testbench
